// ---- design/scwd_params.svh ----
/*
 Constants of the serial command word decoder: frame length, field positions
 and the reserved data patterns.
 Assumes it is included by bare name into the package and the design files.
*/
// Behaviour
// RL1 - A set top command bit makes the frame a readback and never a write.
// RL2 - A readback target is chosen only from the channel mask and the register-set selector.
// RL3 - Mask bit 0 selects channel 0 and mask bit 3 selects channel 3.
// RL4 - A write with a nonzero mask updates every channel whose mask bit is set.
// RL5 - A write with zero mask and zero selector updates the system control register.
// RL6 - A zero-mask write with selector 11 and all-ones data is a no-operation.
// RL7 - The host should send the no-operation when it only wants readback data clocked out.
// RL8 - The host never sends reserved codes; the device flags them.
// RL9 - A zero-mask write with selector 11 must carry all-ones data.
// RL10 - A per-channel readback sets exactly one mask bit and returns one register.
// RL11 - Status, system control and channel-function readbacks carry all-zero data.
// RL12 - A DAC readback carries the DAC address on top and zeros below.
// RL13 - Every frame is twenty-nine bits, sent most significant bit first.
// RL14 - Selector 00 is control, 01 DAC gain, 10 DAC offset, 11 DAC input data.
// RL15 - A command is decoded only after a whole frame ends with frame select high.
`ifndef SCWD_PARAMS_SVH
`define SCWD_PARAMS_SVH
`define SCWD_FRAME_BITS   29
`define SCWD_CNT_W        5
`define SCWD_RW_POS       28
`define SCWD_MASK_HI      27
`define SCWD_MASK_LO      24
`define SCWD_SEL_HI       23
`define SCWD_SEL_LO       22
`define SCWD_DATA_HI      21
`define SCWD_DATA_W       22
`define SCWD_DAC_ADDR_W   6
`define SCWD_DATA_ONES    22'h3fffff
`define SCWD_DATA_ZERO    22'h000000
`define SCWD_SYNC_IDLE    3'h7
`endif

// ---- design/scwd_pkg.sv ----
/*
 Types of the serial command word decoder.
 Assumes scwd_params.svh is on the include path.
*/
`include "scwd_params.svh"
package scwd_pkg;
   // Register-set selector codes.
   typedef enum logic [1:0]
   {
      SCWD_SEL_CTRL   = 2'h0,
      SCWD_SEL_GAIN   = 2'h1,
      SCWD_SEL_OFFSET = 2'h2,
      SCWD_SEL_INPUT  = 2'h3
   } scwd_sel_e;
   // Decoded action of one frame.
   typedef enum logic [3:0]
   {
      SCWD_ACT_NONE      = 4'h0,
      SCWD_ACT_WR_SYSCTL = 4'h1,
      SCWD_ACT_WR_CHAN   = 4'h2,
      SCWD_ACT_NOP       = 4'h3,
      SCWD_ACT_RD_SYSCTL = 4'h4,
      SCWD_ACT_RD_COMP   = 4'h5,
      SCWD_ACT_RD_ALARM  = 4'h6,
      SCWD_ACT_RD_CHAN   = 4'h7,
      SCWD_ACT_RESERVED  = 4'h8
   } scwd_act_e;
   // Frame receiver state.
   typedef struct packed
   {
      logic [2:0]  clk_sync;
      logic [2:0]  sel_sync;
      logic [1:0]  din_sync;
      logic [28:0] shift;
      logic [4:0]  count;
      logic        overrun;
      logic        frame_ok;
      logic        frame_bad;
      logic [28:0] word;
   } scwd_rx_s;
   // Decoder state.
   typedef struct packed
   {
      logic        valid;
      scwd_act_e   act;
      logic        rd;
      logic [3:0]  mask;
      scwd_sel_e   sel;
      logic [21:0] data;
      logic        reserved;
      logic        dropped;
   } scwd_dec_s;
endpackage

// ---- design/scwd_rx.sv ----
/*
 Frame receiver: samples the serial clock, frame select and data pins on the
 system clock and delivers a full 29-bit word when frame select rises.
 Assumes the serial clock is several system clocks per half period.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scwd_params.svh"
module scwd_rx
   import scwd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_sclk,
   input  wire logic        i_sync_b,
   input  wire logic        i_sdi,
   output logic             o_frame_ok,
   output logic             o_frame_bad,
   output logic [28:0]      o_word
);
   scwd_rx_s state;
   scwd_rx_s next_state;

   ////////////////////////////////////////////////////////////////////////////
   // Shift on falling serial clock edges while frame select is low, MSB first.
   always_comb
   begin
      next_state = state;
      next_state.clk_sync = {state.clk_sync[1:0], i_sclk};
      next_state.sel_sync = {state.sel_sync[1:0], i_sync_b};
      next_state.din_sync = {state.din_sync[0], i_sdi};
      next_state.frame_ok = 1'b0;
      next_state.frame_bad = 1'b0;
      if (!state.sel_sync[2] && state.clk_sync[2] && !state.clk_sync[1] && !state.sel_sync[1])
      begin
         next_state.shift = {state.shift[27:0], state.din_sync[1]}; // RL13
         if (state.count == 5'(`SCWD_FRAME_BITS))
            next_state.overrun = 1'b1;
         else
            next_state.count = state.count + 5'h01;
      end
      if (!state.sel_sync[2] && state.sel_sync[1])
      begin
         // Only an exact-length frame is delivered; others are discarded.
         if (state.count == 5'(`SCWD_FRAME_BITS) && !state.overrun) // RL15
         begin
            next_state.frame_ok = 1'b1;
            next_state.word = state.shift;
         end
         else
            next_state.frame_bad = 1'b1;
         next_state.count = 5'h00;
         next_state.overrun = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         state <= '0;
         // The clock and frame-select synchronisers start at the idle pin level so that no false edge follows reset.
         state.clk_sync <= `SCWD_SYNC_IDLE;
         state.sel_sync <= `SCWD_SYNC_IDLE;
      end
      else
         state <= next_state;
   end

   assign o_frame_ok = state.frame_ok;
   assign o_frame_bad = state.frame_bad;
   assign o_word = state.word;
endmodule
`default_nettype wire

// ---- design/scwd_decoder.sv ----
/*
 Serial command word decoder: receives 29-bit command frames and classifies
 each into a system control write, a multi-channel write, a no-operation,
 a readback of one register, or a reserved code.
 Assumes the host keeps to the frame format; outputs are one-cycle strobes
 with fields held until the next complete frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "scwd_params.svh"
module scwd_decoder
   import scwd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_sclk,
   input  wire logic        i_sync_b,
   input  wire logic        i_sdi,
   output logic             o_cmd_valid,
   output scwd_act_e        o_cmd_action,
   output logic             o_cmd_read,
   output logic [3:0]       o_chan_mask,
   output scwd_sel_e        o_reg_set,
   output logic [21:0]      o_data,
   output logic             o_reserved,
   output logic             o_frame_dropped
);
   scwd_dec_s   state;
   scwd_dec_s   next_state;
   logic        frame_ok;
   logic        frame_bad;
   logic [28:0] word;

   ////////////////////////////////////////////////////////////////////////////
   // Frame receiver.
   scwd_rx u_rx
   (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_sclk      (i_sclk),
      .i_sync_b    (i_sync_b),
      .i_sdi       (i_sdi),
      .o_frame_ok  (frame_ok),
      .o_frame_bad (frame_bad),
      .o_word      (word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // True when exactly one mask bit is set.
   function automatic logic one_hot(input logic [3:0] m);
      one_hot = (m == 4'h1) || (m == 4'h2) || (m == 4'h4) || (m == 4'h8);
   endfunction

   // Classifies one command word.
   function automatic scwd_act_e classify(input logic [28:0] w);
      logic        rd;
      logic [3:0]  mask;
      scwd_sel_e   sel;
      logic [21:0] data;
      rd = w[`SCWD_RW_POS];
      mask = w[`SCWD_MASK_HI:`SCWD_MASK_LO]; // RL3
      sel = scwd_sel_e'(w[`SCWD_SEL_HI:`SCWD_SEL_LO]); // RL14
      data = w[`SCWD_DATA_HI:0];
      classify = SCWD_ACT_RESERVED; // RL8
      if (!rd)
      begin
         if (mask != 4'h0)
            classify = SCWD_ACT_WR_CHAN; // RL4
         else
         begin
            case (sel)
               SCWD_SEL_CTRL:  classify = SCWD_ACT_WR_SYSCTL; // RL5
               SCWD_SEL_INPUT:
                  if (data == `SCWD_DATA_ONES)
                     classify = SCWD_ACT_NOP; // RL6
               default:        classify = SCWD_ACT_RESERVED;
            endcase
         end
      end
      else
      begin
         // Readback target follows from mask and selector alone.
         if (mask == 4'h0) // RL2
         begin
            case (sel)
               SCWD_SEL_CTRL:   classify = SCWD_ACT_RD_SYSCTL;
               SCWD_SEL_GAIN:   classify = SCWD_ACT_RD_COMP;
               SCWD_SEL_INPUT:  classify = SCWD_ACT_RD_ALARM;
               default:         classify = SCWD_ACT_RESERVED;
            endcase
         end
         else if (one_hot(mask))
            classify = SCWD_ACT_RD_CHAN; // RL10
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Latch the fields and the action of each complete frame.
   always_comb
   begin
      next_state = state;
      next_state.valid = 1'b0;
      next_state.dropped = frame_bad; // RL15
      if (frame_ok)
      begin
         next_state.valid = 1'b1;
         next_state.act = classify(word);
         next_state.rd = word[`SCWD_RW_POS]; // RL1
         next_state.mask = word[`SCWD_MASK_HI:`SCWD_MASK_LO];
         next_state.sel = scwd_sel_e'(word[`SCWD_SEL_HI:`SCWD_SEL_LO]);
         next_state.data = word[`SCWD_DATA_HI:0];
         next_state.reserved = (classify(word) == SCWD_ACT_RESERVED);
      end
   end

   // State register.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
         state <= '0;
      else
         state <= next_state;
   end

   assign o_cmd_valid = state.valid;
   assign o_cmd_action = state.act;
   assign o_cmd_read = state.rd;
   assign o_chan_mask = state.mask;
   assign o_reg_set = state.sel;
   assign o_data = state.data;
   assign o_reserved = state.reserved;
   assign o_frame_dropped = state.dropped;
endmodule
`default_nettype wire

// ---- verification/scwd_chk.sv ----
/*
 Assertions on the command word decoder outputs.
 Assumes it is bound to scwd_decoder and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module scwd_chk
   import scwd_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   input wire logic        i_sync_b,
   input wire logic        o_cmd_valid,
   input wire scwd_act_e   o_cmd_action,
   input wire logic        o_cmd_read,
   input wire logic [3:0]  o_chan_mask,
   input wire scwd_sel_e   o_reg_set,
   input wire logic [21:0] o_data,
   input wire logic        o_reserved,
   input wire logic        o_frame_dropped
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // Decoded writes and reads, qualified by the strobe.
   wire logic wr = o_cmd_valid && !o_cmd_read;
   wire logic rd = o_cmd_valid && o_cmd_read;
   wire logic z  = o_chan_mask == 4'h0;
   ////////////////////////////////////////////////////////////////////////
   a_read_no_write: assert property (rd |-> !(o_cmd_action inside
      {SCWD_ACT_WR_SYSCTL, SCWD_ACT_WR_CHAN, SCWD_ACT_NOP})) else $error("read became write");
   a_sysctl_write: assert property (wr && z && o_reg_set == SCWD_SEL_CTRL
      |-> o_cmd_action == SCWD_ACT_WR_SYSCTL) else $error("system write misdecoded");
   a_multi_write: assert property (wr && !z
      |-> o_cmd_action == SCWD_ACT_WR_CHAN) else $error("channel write misdecoded");
   a_nop_code: assert property (wr && z && o_reg_set == SCWD_SEL_INPUT && &o_data
      |-> o_cmd_action == SCWD_ACT_NOP) else $error("no-op misdecoded");
   a_status_read: assert property (rd && z |-> o_cmd_action ==
      (o_reg_set == SCWD_SEL_CTRL ? SCWD_ACT_RD_SYSCTL : o_reg_set == SCWD_SEL_GAIN ?
      SCWD_ACT_RD_COMP : o_reg_set == SCWD_SEL_INPUT ? SCWD_ACT_RD_ALARM :
      SCWD_ACT_RESERVED)) else $error("status read misdecoded");
   a_one_chan_read: assert property (rd && !z |-> o_cmd_action ==
      ($onehot(o_chan_mask) ? SCWD_ACT_RD_CHAN : SCWD_ACT_RESERVED))
      else $error("channel read misdecoded");
   a_reserved_flag: assert property (o_cmd_valid
      |-> o_reserved == (o_cmd_action == SCWD_ACT_RESERVED)) else $error("reserved flag wrong");
   a_answer_bound: assert property ($rose(i_sync_b)
      |-> ##[2:6] (o_cmd_valid || o_frame_dropped)) else $error("no answer to frame end");
   a_valid_after_end: assert property (o_cmd_valid |-> $past(i_sync_b, 2) &&
      !o_frame_dropped ##1 !o_cmd_valid) else $error("strobe out of place");
   a_drop_holds: assert property (o_frame_dropped
      |-> $stable({o_cmd_read, o_chan_mask, o_reg_set, o_data})) else $error("fields moved");
   c_nop: cover property (o_cmd_valid && o_cmd_action == SCWD_ACT_NOP);
   c_drop: cover property (o_frame_dropped);
   c_all: cover property (wr && o_chan_mask == 4'hf);
endmodule
bind scwd_decoder scwd_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_sync_b(i_sync_b),
   .o_cmd_valid(o_cmd_valid), .o_cmd_action(o_cmd_action), .o_cmd_read(o_cmd_read),
   .o_chan_mask(o_chan_mask), .o_reg_set(o_reg_set), .o_data(o_data),
   .o_reserved(o_reserved), .o_frame_dropped(o_frame_dropped));
`default_nettype wire

// ---- verification/scwd_host.sv ----
/*
 Host model that shifts command frames into the serial pins.
 Assumes a 20 ns system clock; the serial clock runs at 160 ns in frames.
*/
`timescale 1ns/1ps
`default_nettype none
module scwd_host
(
   input  wire logic i_clk,
   output logic      o_sclk,
   output logic      o_sync_b,
   output logic      o_sdi
);
   // Pins idle high with the serial clock standing still.
   initial
   begin
      o_sclk = 1'b1;
      o_sync_b = 1'b1;
      o_sdi = 1'b1;
   end
   // Sends n bits of v, top bit first; bits past 29 are zeros.
   task automatic send(input logic [28:0] v, input int n);
      logic b;
      @(posedge i_clk);
      o_sync_b <= 1'b0;
      for (int k = 0; k < n; k++)
      begin
         b = (k < 29) ? v[28 - k] : 1'b0;
         o_sdi <= b;
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b0;
         repeat (4) @(posedge i_clk);
         o_sclk <= 1'b1;
      end
      repeat (4) @(posedge i_clk);
      o_sync_b <= 1'b1;
      o_sdi <= ~b; // The released line never shows the last bit.
      repeat (10) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ---- verification/test_scwd_decoder.sv ----
/*
 Self-checking bench of the command word decoder.
 Assumes the host model drives the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
module test_scwd_decoder
   import scwd_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   wire logic   sclk, sync_b, sdi, valid, rd, rsv, drop;
   scwd_act_e   act;
   wire [3:0]   mask;
   scwd_sel_e   sel;
   wire [21:0]  data;
   logic [35:0] expq[$];
   logic [33:0] last = '0;
   logic [35:0] e;
   logic [21:0] d;
   int          failures = 0;
   int          checks_done = 0;
   int          r;
   always #10 clk = ~clk;
   scwd_host u_scwd_host (.i_clk(clk), .o_sclk(sclk), .o_sync_b(sync_b), .o_sdi(sdi));
   scwd_decoder u_scwd_decoder (.i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk),
      .i_sync_b(sync_b), .i_sdi(sdi), .o_cmd_valid(valid), .o_cmd_action(act),
      .o_cmd_read(rd), .o_chan_mask(mask), .o_reg_set(sel), .o_data(data),
      .o_reserved(rsv), .o_frame_dropped(drop));
   ////////////////////////////////////////////////////////////////////////
   // Expected action, reserved flag and fields of a whole frame.
   function automatic logic [33:0] expect_of(input logic [28:0] v);
      logic [3:0] a;
      logic [1:0] s;
      s = v[23:22];
      a = v[28] ? (v[27:24] == 4'h0 ? (s == 2'h0 ? 4'h4 : s == 2'h1 ? 4'h5 :
         s == 2'h3 ? 4'h6 : 4'h8) : $onehot(v[27:24]) ? 4'h7 : 4'h8) :
         (v[27:24] != 4'h0 ? 4'h2 : s == 2'h0 ? 4'h1 : (s == 2'h3 && &v[21:0]) ? 4'h3 : 4'h8);
      return {a, a == 4'h8, v};
   endfunction
   // Notes the expectation, then sends the frame.
   task automatic frame(input logic [28:0] v, input int n);
      if (n == 29)
         last = expect_of(v);
      expq.push_back({n == 29, n != 29, last});
      u_scwd_host.send(v, n);
   endtask
   task automatic summarize();
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Takes the oldest note whenever a result strobe appears, away from the launching edge.
   always @(negedge clk)
      if (rst_b && (valid || drop))
      begin
         e = (expq.size() > 0) ? expq.pop_front() : '1;
         checks_done++;
         if (e !== {valid, drop, act, rsv, rd, mask, sel, data})
         begin
            failures++;
            $display("CHECK FAILED result exp %h got %h", e,
               {valid, drop, act, rsv, rd, mask, sel, data});
         end
      end
   // Watchdog against a hang: about 152 frames of some 250 cycles each need near 0.76 ms.
   initial
   begin
      #1200000;
      failures++;
      summarize();
   end
   // Main sequence.
   initial
   begin
      r = $urandom(32'h98787463);
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 128; i++)
      begin
         d = i[6] ? ((i[5:2] != 0 && i[1:0] != 0) ? {6'($urandom), 16'h0} : 22'h0) :
            ((i[5:2] == 0 && i[1:0] == 3) ? 22'h3fffff : 22'($urandom));
         frame({i[6], i[5:2], i[1:0], d}, 29);
      end
      frame({7'h03, 22'h3ffffe}, 29);
      frame({7'h42, 22'h15a5a5}, 29);
      frame({7'h2b, 22'h0}, 28);
      frame({7'h2b, 22'h0}, 30);
      for (int i = 0; i < 20; i++)
         frame(29'($urandom), 29);
      repeat (20) @(posedge clk);
      if (expq.size() != 0)
      begin
         failures++;
         $display("CHECK FAILED pending results exp %0d got %0d", 0, expq.size());
      end
      summarize();
   end
endmodule
`default_nettype wire
